//--- tmr_ctrl_defs.vh
// Constants for the timer input-side slave control block.
// Assumes a single 25 MHz kernel clock and an APB master with 32-bit data.
//
// Contract
// - Clear enable plus high filtered trigger forces reference low until update.
// - Reference clearing only in compare and PWM modes, not forced modes.
// - With compare above reload, cleared reference returns at next overflow.
// - Slave mode 001, 010, 011 select encoder on input two, one, both.
// - Encoder counts each valid filtered transition only while run bit set.
// - Direction recomputed at every transition of either input; here not in a cycle that takes an APB write.
// - Encoder counter wraps between 0 and auto-reload in both directions.
// - Capture, compare, prescaler, trigger output keep working in encoder mode; here encoder steps bypass the prescaler, which holds.
// - Input-one edge counts; rising down if input two high, else up.
// - Input-two edge counts; rising up if input one high, else down.
// - Xor select feeds channel-one filter with xor of pins one to three.
// - Xor signal serves every input function, trigger and capture.
// - Reset mode trigger reinitialises counter, prescaler; update unless source bit.
// - Slave mode 100 is reset; trigger select 101 picks filtered input one; here only while input select is 01.
// - Slave trigger sets trigger flag; requests interrupt or DMA if enabled.
// - Input select 01 maps input one to channel one; polarity 0 is rising.
// - Trigger inputs resynchronised, counter reset after short fixed delay.
// - Update event loads preload into shadow; update generate bit forces one.
`ifndef TMR_CTRL_DEFS_VH
`define TMR_CTRL_DEFS_VH

`define ADDR_CTRL      12'h000
`define ADDR_SLAVE     12'h004
`define ADDR_CHAN      12'h008
`define ADDR_EVENT     12'h00C
`define ADDR_STATUS    12'h010
`define ADDR_COUNT     12'h014
`define ADDR_PRESCALE  12'h018
`define ADDR_RELOAD    12'h01C
`define ADDR_COMPARE   12'h020

// Control word fields
`define CTRL_RUN       0
`define CTRL_UPD_SRC   2
`define CTRL_DIR       4
`define CTRL_XOR_SEL   7
`define CTRL_TRG_IE    8
`define CTRL_TRG_DE    9

// Slave word fields
`define SLV_MODE_LO    0
`define SLV_TSEL_LO    4
`define SLV_ETF_LO     8
`define SLV_EXT_TRIGGER_PRESCALE_LO    12
`define SLV_ECE        14
`define SLV_ETP        15

// Channel word fields
`define CH_ISEL_LO     0
`define CH_OMODE_LO    4
`define CH_CLR_EN      7
`define CH1_POL        8
`define CH1_NPOL       9
`define CH2_POL        10
`define CH2_NPOL       11

`define SMS_OFF        3'h0
`define SMS_ENC_TWO    3'h1
`define SMS_ENC_ONE    3'h2
`define SMS_ENC_BOTH   3'h3
`define SMS_RESET      3'h4
`define TS_INPUT_ONE   3'h5
`define TS_INPUT_TWO   3'h6
`define TS_EXT_TRIG    3'h7

`define OM_FROZEN      3'h0
`define OM_FORCE_LOW   3'h4
`define OM_FORCE_HIGH  3'h5
`define OM_PWM1        3'h6
`define OM_PWM2        3'h7

`define RESET_ZERO     32'h00000000
`define RELOAD_RESET   16'hFFFF

`endif

//--- tmr_ctrl.v
// Timer input-side control: encoder, xor combiner, reset slave mode,
// reference clear by filtered external trigger, one compare channel.
// Assumes pins asynchronous to the core clock; APB slave, zero wait.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "tmr_ctrl_defs.vh"

module tmr_ctrl #(
   parameter CW = 16
) (
   input  wire        CORE_CLK_IN,
   input  wire        RST_IN,
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [11:0] PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output wire [31:0] PRDATA_OUT,
   output wire        PREADY_OUT,
   output wire        PSLVERR_OUT,
   input  wire        CH1_PIN_IN,
   input  wire        CH2_PIN_IN,
   input  wire        CH3_PIN_IN,
   input  wire        EXT_TRIGGER_PIN_IN,
   output reg         OC_REF_OUT,
   output reg         TRIGGER_IRQ_OUT,
   output reg         TRIGGER_DMA_OUT,
   output reg         UPDATE_EVENT_OUT
);

   reg  [31:0] ctrl;
   reg  [31:0] slave;
   reg  [31:0] chan;
   reg         trigger_flag;
   reg         update_flag;
   reg         capture_flag;
   reg [CW-1:0] count;
   reg [CW-1:0] prescale;
   reg [CW-1:0] psc_count;
   reg [CW-1:0] reload;
   reg [CW-1:0] reload_pre;
   reg [CW-1:0] compare;
   reg [CW-1:0] compare_pre;
   reg [CW-1:0] capture;
   reg  [31:0] rdata;
   reg         ref_cleared;

   // Two-flop synchronisers, one per input, plus last-value stage
   wire [3:0] raw_pins;
   reg  [3:0] sync_a;
   reg  [3:0] sync_b;
   reg  [3:0] sync_c;

   function [2:0] edge_kind;
      input cur;
      input prev;
      begin
         edge_kind = {cur & ~prev, ~cur & prev, cur ^ prev};
      end
   endfunction

   wire xor_in = CH1_PIN_IN ^ CH2_PIN_IN ^ CH3_PIN_IN;
   // Xor output replaces pin one for every downstream use
   assign raw_pins = {EXT_TRIGGER_PIN_IN, CH3_PIN_IN, CH2_PIN_IN,
                      ctrl[`CTRL_XOR_SEL] ? xor_in : CH1_PIN_IN};

   always @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
         sync_c <= 4'h0;
      end else begin
         sync_a <= raw_pins;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   // Polarity applied after sync; negative bits ignored (software keeps them 0)
   wire in1 = sync_b[0] ^ chan[`CH1_POL];
   wire in2 = sync_b[1] ^ chan[`CH2_POL];
   wire in1_d = sync_c[0] ^ chan[`CH1_POL];
   wire in2_d = sync_c[1] ^ chan[`CH2_POL];
   wire filtered_ext_trigger = sync_b[3] ^ slave[`SLV_ETP];
   wire [2:0] e1 = edge_kind(in1, in1_d);
   wire [2:0] e2 = edge_kind(in2, in2_d);

   wire [2:0] slave_mode_select   = slave[`SLV_MODE_LO +: 3];
   wire [2:0] tsel  = slave[`SLV_TSEL_LO +: 3];
   wire [1:0] isel  = chan[`CH_ISEL_LO +: 2];
   wire [2:0] omode = chan[`CH_OMODE_LO +: 3];
   wire run = ctrl[`CTRL_RUN];
   wire enc_mode = (slave_mode_select == `SMS_ENC_TWO) || (slave_mode_select == `SMS_ENC_ONE) ||
                   (slave_mode_select == `SMS_ENC_BOTH);
   wire cnt_one = (slave_mode_select == `SMS_ENC_ONE) || (slave_mode_select == `SMS_ENC_BOTH);
   wire cnt_two = (slave_mode_select == `SMS_ENC_TWO) || (slave_mode_select == `SMS_ENC_BOTH);

   // Input-one edge: rising counts down when input two high
   wire one_down = e1[2] ? in2 : ~in2;
   // Input-two edge: rising counts up when input one high
   wire two_down = e2[2] ? ~in1 : in1;
   wire enc_step = run && ((cnt_one && e1[0]) || (cnt_two && e2[0]));
   wire enc_down = e1[0] ? one_down : two_down;

   // Trigger source selection; rising edge of selected filtered input
   reg trig_edge;
   always @* begin
      case (tsel)
         `TS_INPUT_ONE: trig_edge = e1[2] && (isel == 2'h1);
         `TS_INPUT_TWO: trig_edge = e2[2];
         `TS_EXT_TRIG:  trig_edge = filtered_ext_trigger & ~(sync_c[3] ^ slave[`SLV_ETP]);
         default:       trig_edge = 1'b0;
      endcase
   end
   wire reset_trig = (slave_mode_select == `SMS_RESET) && trig_edge;

   wire apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
   wire ug_wr  = apb_wr && (PADDR_IN == `ADDR_EVENT) && PWDATA_IN[0];
   wire tg_wr  = apb_wr && (PADDR_IN == `ADDR_EVENT) && PWDATA_IN[6];
   wire psc_tick = (psc_count == prescale);
   wire up = ~ctrl[`CTRL_DIR];
   wire overflow = enc_mode ?
      (enc_step && (enc_down ? count == {CW{1'b0}} : count == reload)) :
      (run && psc_tick && (up ? count == reload : count == {CW{1'b0}}));
   // Reset trigger makes an update unless update source restricts it
   wire upd = overflow || ug_wr ||
              (reset_trig && !ctrl[`CTRL_UPD_SRC]);

   always @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         ctrl <= `RESET_ZERO;
         slave <= `RESET_ZERO;
         chan <= `RESET_ZERO;
         prescale <= {CW{1'b0}};
         reload_pre <= `RELOAD_RESET;
         compare_pre <= {CW{1'b0}};
      end else if (apb_wr) begin
         case (PADDR_IN)
            `ADDR_CTRL:     ctrl <= PWDATA_IN & 32'h0000039D;
            `ADDR_SLAVE:    slave <= PWDATA_IN & 32'h0000FF77;
            `ADDR_CHAN:     chan <= PWDATA_IN & 32'h00000FF3;
            `ADDR_PRESCALE: prescale <= PWDATA_IN[CW-1:0];
            `ADDR_RELOAD:   reload_pre <= PWDATA_IN[CW-1:0];
            `ADDR_COMPARE:  compare_pre <= PWDATA_IN[CW-1:0];
            default:        ctrl <= ctrl;
         endcase
      end else if (enc_mode && (e1[0] || e2[0])) begin
         ctrl[`CTRL_DIR] <= enc_down;
      end
   end

   // Counter, prescaler, shadow loads
   always @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         count <= {CW{1'b0}};
         psc_count <= {CW{1'b0}};
         reload <= `RELOAD_RESET;
         compare <= {CW{1'b0}};
      end else begin
         if (upd) begin
            reload <= reload_pre;
            compare <= compare_pre;
         end
         if (reset_trig || ug_wr) begin
            count <= {CW{1'b0}};
            psc_count <= {CW{1'b0}};
         end else if (apb_wr && PADDR_IN == `ADDR_COUNT) begin
            count <= PWDATA_IN[CW-1:0];
         end else if (enc_mode) begin
            // Encoder acts as clock with direction; wraps both ways
            if (enc_step) begin
               if (enc_down)
                  count <= (count == {CW{1'b0}}) ? reload : count - 1'b1;
               else
                  count <= (count == reload) ? {CW{1'b0}} : count + 1'b1;
            end
         end else if (run) begin
            psc_count <= psc_tick ? {CW{1'b0}} : psc_count + 1'b1;
            if (psc_tick) begin
               if (up)
                  count <= (count == reload) ? {CW{1'b0}} : count + 1'b1;
               else
                  count <= (count == {CW{1'b0}}) ? reload : count - 1'b1;
            end
         end
      end
   end

   // Reference output with external clear; compare path shared by all
   // counting modes, encoder included
   wire cmp_mode = (omode != `OM_FORCE_LOW) && (omode != `OM_FORCE_HIGH);
   reg  ref_raw;
   always @* begin
      case (omode)
         `OM_FORCE_LOW:  ref_raw = 1'b0;
         `OM_FORCE_HIGH: ref_raw = 1'b1;
         `OM_PWM1:       ref_raw = count < compare;
         `OM_PWM2:       ref_raw = !(count < compare);
         default:        ref_raw = count == compare;
      endcase
   end

   always @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         ref_cleared <= 1'b0;
         OC_REF_OUT <= 1'b0;
      end else begin
         // Clear holds until the update; overflow is an update so the
         // 100% duty case comes back there too
         if (chan[`CH_CLR_EN] && filtered_ext_trigger && cmp_mode)
            ref_cleared <= 1'b1;
         else if (upd)
            ref_cleared <= 1'b0;
         // Forced modes bypass the clear entirely
         OC_REF_OUT <= cmp_mode ? (ref_raw & ~ref_cleared) : ref_raw;
      end
   end

   // Status flags; hardware set wins over software clear
   wire sr_wr = apb_wr && (PADDR_IN == `ADDR_STATUS);
   wire cap_evt = (isel == 2'h1) && e1[2];
   always @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         trigger_flag <= 1'b0;
         update_flag <= 1'b0;
         capture_flag <= 1'b0;
         capture <= {CW{1'b0}};
         TRIGGER_IRQ_OUT <= 1'b0;
         TRIGGER_DMA_OUT <= 1'b0;
         UPDATE_EVENT_OUT <= 1'b0;
      end else begin
         if (reset_trig || tg_wr)
            trigger_flag <= 1'b1;
         else if (sr_wr && !PWDATA_IN[6])
            trigger_flag <= 1'b0;
         if (upd)
            update_flag <= 1'b1;
         else if (sr_wr && !PWDATA_IN[0])
            update_flag <= 1'b0;
         if (cap_evt) begin
            capture_flag <= 1'b1;
            capture <= count;
         end else if (sr_wr && !PWDATA_IN[1]) begin
            capture_flag <= 1'b0;
         end
         TRIGGER_IRQ_OUT <= trigger_flag && ctrl[`CTRL_TRG_IE];
         TRIGGER_DMA_OUT <= (reset_trig || tg_wr) && ctrl[`CTRL_TRG_DE];
         UPDATE_EVENT_OUT <= upd;
      end
   end

   always @* begin
      case (PADDR_IN)
         `ADDR_CTRL:     rdata = ctrl;
         `ADDR_SLAVE:    rdata = slave;
         `ADDR_CHAN:     rdata = chan;
         `ADDR_STATUS:   rdata = {25'h0, trigger_flag, 4'h0,
                                  capture_flag, update_flag};
         `ADDR_COUNT:    rdata = {{(32-CW){1'b0}}, count};
         `ADDR_PRESCALE: rdata = {{(32-CW){1'b0}}, prescale};
         `ADDR_RELOAD:   rdata = {{(32-CW){1'b0}}, reload_pre};
         `ADDR_COMPARE:  rdata = {{(32-CW){1'b0}}, capture};
         default:        rdata = `RESET_ZERO;
      endcase
   end

   // Zero-wait slave; unmapped addresses flag an error
   assign PREADY_OUT = 1'b1;
   assign PRDATA_OUT = (PSEL_IN && !PWRITE_IN) ? rdata : `RESET_ZERO;
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN &&
                        ((PADDR_IN > `ADDR_COMPARE) || (PADDR_IN[1:0] != 2'h0));

endmodule

//--- tmr_ctrl_properties.sv
// Port-level checker for the timer slave control block.
// Assumes APB writes land on PSEL&PENABLE&PREADY; shadows track them.
`timescale 1ns/10ps
`include "tmr_ctrl_defs.vh"
module tmr_ctrl_properties #(
   parameter CW = 16
) (
   input wire        CORE_CLK_IN,
   input wire        RST_IN,
   input wire        PSEL_IN,
   input wire        PENABLE_IN,
   input wire        PWRITE_IN,
   input wire [11:0] PADDR_IN,
   input wire [31:0] PWDATA_IN,
   input wire [31:0] PRDATA_OUT,
   input wire        PREADY_OUT,
   input wire        PSLVERR_OUT,
   input wire        CH1_PIN_IN,
   input wire        CH2_PIN_IN,
   input wire        CH3_PIN_IN,
   input wire        EXT_TRIGGER_PIN_IN,
   input wire        OC_REF_OUT,
   input wire        TRIGGER_IRQ_OUT,
   input wire        TRIGGER_DMA_OUT,
   input wire        UPDATE_EVENT_OUT
);
   reg  [15:0] ctl;
   reg  [15:0] slv;
   reg  [15:0] chn;
   wire        wr = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
   // Shadows of the control words; dir bit is not tracked
   always @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         ctl <= 16'h0000;
         slv <= 16'h0000;
         chn <= 16'h0000;
      end else if (wr) begin
         if (PADDR_IN == `ADDR_CTRL) ctl <= PWDATA_IN[15:0];
         if (PADDR_IN == `ADDR_SLAVE) slv <= PWDATA_IN[15:0];
         if (PADDR_IN == `ADDR_CHAN) chn <= PWDATA_IN[15:0];
      end
   end
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   AST_QUIET: assert property ($past(RST_IN) |-> !(OC_REF_OUT |
      TRIGGER_IRQ_OUT | TRIGGER_DMA_OUT | UPDATE_EVENT_OUT))
      else $error("output active right after reset");
   AST_CLEAR: assert property ((EXT_TRIGGER_PIN_IN && chn[7] &&
      chn[6:4] >= `OM_PWM1 && !slv[`SLV_ETP])[*5] |-> !OC_REF_OUT)
      else $error("reference not cleared by trigger");
   AST_FORCE: assert property ((chn[6:4] == `OM_FORCE_HIGH)[*3]
      |-> OC_REF_OUT) else $error("forced high reference dropped");
   AST_TRIG_UPD: assert property (slv[2:0] == `SMS_RESET &&
      slv[6:4] == `TS_INPUT_ONE && chn[1:0] == 2'h1 && !chn[8] &&
      !ctl[7] && !ctl[2] && $rose(CH1_PIN_IN) |-> ##[1:5] UPDATE_EVENT_OUT)
      else $error("reset trigger gave no update");
   AST_IRQ: assert property (TRIGGER_IRQ_OUT |->
      $past(ctl[`CTRL_TRG_IE])) else $error("irq without enable");
   AST_DMA: assert property (TRIGGER_DMA_OUT |->
      $past(ctl[`CTRL_TRG_DE]) ##1 !TRIGGER_DMA_OUT)
      else $error("dma request bad");
   AST_UG: assert property (wr && PADDR_IN == `ADDR_EVENT &&
      PWDATA_IN[0] |-> ##[1:3] UPDATE_EVENT_OUT)
      else $error("update generate gave no update");
   AST_UPD_PULSE: assert property (UPDATE_EVENT_OUT |=>
      !UPDATE_EVENT_OUT) else $error("update pulse too long");
   AST_SLVERR: assert property (PSEL_IN && PENABLE_IN &&
      PADDR_IN > `ADDR_COMPARE |-> PSLVERR_OUT)
      else $error("unmapped access not refused");
   cover property ($rose(TRIGGER_IRQ_OUT));
   cover property (UPDATE_EVENT_OUT);
   cover property ($fell(OC_REF_OUT));
endmodule

bind tmr_ctrl tmr_ctrl_properties #(.CW(CW)) u_tmr_ctrl_properties (
   .CORE_CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN,
   .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .CH1_PIN_IN,
   .CH2_PIN_IN, .CH3_PIN_IN, .EXT_TRIGGER_PIN_IN, .OC_REF_OUT,
   .TRIGGER_IRQ_OUT, .TRIGGER_DMA_OUT, .UPDATE_EVENT_OUT);

//--- quad_encoder_model.sv
// Quadrature encoder and current comparator on the timer pins.
// Assumes one step request per cycle; lines change one at a time.
`timescale 1ns/10ps
module quad_encoder_model (
   input  wire clk_in,
   input  wire step_in,
   input  wire back_in,
   input  wire over_in,
   output wire a_out,
   output wire b_out,
   output wire trig_out
);
   reg [1:0] ph = 2'h0;
   // Gray order, so the two lines never switch together
   always @(posedge clk_in) begin
      if (step_in) ph <= back_in ? ph - 2'h1 : ph + 2'h1;
   end
   assign a_out    = (ph == 2'h1) || (ph == 2'h2);
   assign b_out    = ph[1];
   assign trig_out = over_in;
endmodule

//--- testbench.sv
// Self-checking bench for the timer slave control block.
// Assumes the encoder model on pins one and two; pin three from here.
`timescale 1ns/10ps
`include "tmr_ctrl_defs.vh"
module testbench;
   reg clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err = 0;
   reg step = 0, back = 0, over = 0, c3 = 0;
   reg [11:0] pa = 12'h000;
   reg [31:0] pwd = 32'h0, q;
   wire [31:0] prd;
   wire prdy, perr, a, b, trig, ref_o, irq, dma, upd;
   integer mismatches = 0, check_count = 0, cyc = 0, n_upd = 0, n_dma = 0, k;
   initial forever #20 clk = ~clk;
   tmr_ctrl u_tmr_ctrl (.CORE_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
      .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
      .CH1_PIN_IN(a), .CH2_PIN_IN(b), .CH3_PIN_IN(c3),
      .EXT_TRIGGER_PIN_IN(trig), .OC_REF_OUT(ref_o), .TRIGGER_IRQ_OUT(irq),
      .TRIGGER_DMA_OUT(dma), .UPDATE_EVENT_OUT(upd));
   quad_encoder_model u_quad_encoder_model (.clk_in(clk), .step_in(step),
      .back_in(back), .over_in(over), .a_out(a), .b_out(b), .trig_out(trig));
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (!rst && upd === 1'b1) n_upd <= n_upd + 1;
      if (!rst && dma === 1'b1) n_dma <= n_dma + 1;
      if (cyc == 8000) begin
         mismatches = mismatches + 1;
         complete_run;
      end
   end
   task check(input [31:0] s, input [31:0] e);
      check_count = check_count + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task apb(input w, input [11:0] ad, input [31:0] d);
      @(posedge clk); psel <= 1; pwr <= w; pa <= ad; pwd <= d;
      @(posedge clk); pen <= 1;
      @(posedge clk);
      while (prdy !== 1'b1) @(posedge clk);
      q = prd;
      err = perr;
      psel <= 0;
      pen <= 0;
   endtask
   task wr(input [11:0] ad, input [31:0] d); apb(1'b1, ad, d); endtask
   task rd(input [11:0] ad); apb(1'b0, ad, 32'h0); endtask
   task idle(input integer n); repeat (n) @(posedge clk); endtask
   // Slow spacing so every step clears the two-flop synchroniser
   task steps(input integer n, input bk);
      integer i;
      for (i = 0; i < n; i = i + 1) begin
         @(posedge clk); step <= 1; back <= bk;
         @(posedge clk); step <= 0;
         idle(6);
      end
   endtask
   task t_reset; begin
      rd(`ADDR_CTRL); check(q, `RESET_ZERO);
      rd(`ADDR_SLAVE); check(q, `RESET_ZERO);
      rd(`ADDR_CHAN); check(q, `RESET_ZERO);
      rd(`ADDR_RELOAD); check(q, {16'h0, `RELOAD_RESET});
      rd(12'h024); check({q[30:0], err}, 32'h1);
      $display("test reset done");
   end endtask
   task t_enc;
      integer m;
      wr(`ADDR_RELOAD, 32'h5); wr(`ADDR_CTRL, 32'h1);
      for (m = 1; m < 4; m = m + 1) begin
         // Polarity left at reset, negative bits clear
         wr(`ADDR_SLAVE, m); wr(`ADDR_EVENT, 32'h1);
         steps(4, 0); rd(`ADDR_COUNT); check(q, (m == 3) ? 4 : 2);
         steps(4, 1); rd(`ADDR_COUNT); check(q, 0);
      end
      steps(1, 1); rd(`ADDR_COUNT); check(q, 5);
      rd(`ADDR_CTRL); check({31'h0, q[`CTRL_DIR]}, 1);
      steps(1, 0); rd(`ADDR_COUNT); check(q, 0);
      wr(`ADDR_CTRL, 32'h0); steps(4, 0);
      rd(`ADDR_COUNT); check(q, 0);
      $display("test encoder done");
   endtask
   task t_rst_mode; begin
      wr(`ADDR_RELOAD, 32'hFFFF); wr(`ADDR_EVENT, 32'h1);
      wr(`ADDR_CHAN, 32'h1); wr(`ADDR_SLAVE, 32'h54);
      wr(`ADDR_CTRL, 32'h301); idle(60);
      k = n_upd; steps(1, 0);
      check(n_upd - k, 1);
      rd(`ADDR_COUNT); check(q < 32'h20, 1);
      check({31'h0, irq}, 1);
      check(n_dma, 1);
      rd(`ADDR_STATUS); check({31'h0, q[6]}, 1);
      wr(`ADDR_STATUS, 32'h0); idle(2); check({31'h0, irq}, 0);
      wr(`ADDR_CTRL, 32'h305); k = n_upd; steps(1, 1); steps(1, 0);
      check(n_upd - k, 0);
      check({31'h0, irq}, 1);
      $display("test reset mode done");
   end endtask
   task t_xor; begin
      wr(`ADDR_CTRL, 32'h381); k = n_upd;
      @(posedge clk); c3 <= 1; idle(8);
      check(n_upd - k, 0);
      @(posedge clk); c3 <= 0; idle(8);
      check(n_upd - k, 1);
      wr(`ADDR_CTRL, 32'h1);
      $display("test xor done");
   end endtask
   task t_clear; begin
      wr(`ADDR_SLAVE, 32'h0); // Prescale 00, clock mode 2 off
      wr(`ADDR_RELOAD, 32'h7); wr(`ADDR_COMPARE, 32'h9);
      wr(`ADDR_EVENT, 32'h1); wr(`ADDR_CHAN, 32'hE0); idle(4);
      check({31'h0, ref_o}, 1);
      @(posedge clk); over <= 1; idle(30);
      check({31'h0, ref_o}, 0);
      @(posedge clk); over <= 0; idle(20);
      check({31'h0, ref_o}, 1);
      wr(`ADDR_CHAN, 32'hD0); @(posedge clk); over <= 1; idle(10);
      check({31'h0, ref_o}, 1);
      over <= 0;
      $display("test clear done");
   end endtask
   task complete_run; begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   end endtask
   initial begin
      idle(10);
      rst <= 0;
      t_reset;
      t_enc;
      t_rst_mode;
      t_xor;
      t_clear;
      complete_run;
   end
endmodule
